// ===== verilog/fbc_ctrl.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// How it works
// - Bypass entry: AA@555, 55@2AA, 20@555.
// - Bypass program: A0 anywhere, then data.
// - Bypass exit: 90 then 00.
// - Only program and exit within bypass (plus hardware reset).
// - Erase evaluation: 35 at sector 555.
// - No evaluation while program/erase active.
// - Blank check: 33 at sector 555.
// - No blank check while program/erase active.
// - Chip erase: six writes, busy after sixth.
// - Hardware reset aborts erase; reissue sequence.
module fbc_ctrl #(
	parameter int ADDR_W     = 26,
	parameter int POLL_LIMIT = 1000000,
	parameter logic [15:0] CHIP_SETUP_DATA = 16'h0080,
	parameter logic [15:0] CHIP_ERASE_DATA = 16'h0010
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic [2:0]        sw_addr,
	input  wire logic [31:0]       sw_wdata,
	input  wire logic              sw_wr,
	input  wire logic              sw_rd,
	output logic      [31:0]       sw_rdata,
	output logic      [ADDR_W-1:0] flash_addr,
	output logic      [15:0]       flash_dq_out,
	output logic                   flash_dq_oe,
	input  wire logic [15:0]       flash_dq_in,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n,
	output logic                   flash_reset_n,
	input  wire logic              ready_busy_n
);
	typedef enum {S_IDLE, S_ISSUE, S_WAIT_WR, S_SETTLE, S_POLL_RD, S_POLL_WAIT,
		S_RST_LOW, S_RST_REC} fbc_st_e;
	typedef struct packed {
		fbc_st_e           st;
		logic [2:0]        op;
		logic [2:0]        idx;
		logic              in_bypass;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       data;
		logic [15:0]       timer;
		logic [31:0]       polls;
		logic              prev;
		logic              first;
		logic              done;
		logic              fail;
		logic              timeout;
		logic              aborted;
		logic              refused;
		logic              cyc_start;
		logic [15:0]       rdata;
		logic [31:0]       sw_rdata;
		logic              rst_pin_n;
	} fbc_ctrl_s;

	fbc_ctrl_s s;
	fbc_ctrl_s next_s;

	logic [15:0] dq_sync;
	logic        rb_sync;
	logic        cyc_done;
	logic [15:0] cyc_rdata;
	logic        wr_cmd;
	logic [2:0]  cmd;
	logic        busy;
	logic        legal;
	logic        poll_end;

	initial begin
		if (ADDR_W <= fbc_pkg::SECT_LSB || ADDR_W > 32) $error("fbc_ctrl: ADDR_W out of range");
		if (POLL_LIMIT < 2) $error("fbc_ctrl: POLL_LIMIT too small");
	end

	function automatic logic [2:0] step_count(input logic [2:0] op);
		case (op)
			fbc_pkg::OP_ENTER: step_count = 3'd3;
			fbc_pkg::OP_PROG:  step_count = 3'd2;
			fbc_pkg::OP_EXIT:  step_count = 3'd2;
			fbc_pkg::OP_EVAL:  step_count = 3'd1;
			fbc_pkg::OP_BLANK: step_count = 3'd1;
			fbc_pkg::OP_CHIP:  step_count = 3'd6;
			default:           step_count = 3'd0;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] step_addr(input logic [2:0] op, input logic [2:0] i,
		input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] sect;
		sect = {a[ADDR_W-1:fbc_pkg::SECT_LSB], fbc_pkg::SECT_LSB'(0)};
		case (op)
			fbc_pkg::OP_ENTER, fbc_pkg::OP_CHIP: begin
				step_addr = (i == 3'd1 || i == 3'd4) ? ADDR_W'(fbc_pkg::ADR_UNLOCK2) :
					ADDR_W'(fbc_pkg::ADR_UNLOCK1);
			end
			fbc_pkg::OP_EVAL, fbc_pkg::OP_BLANK: begin
				step_addr = sect | ADDR_W'(fbc_pkg::ADR_UNLOCK1);
			end
			default: step_addr = a;
		endcase
	endfunction

	function automatic logic [15:0] step_data(input logic [2:0] op, input logic [2:0] i,
		input logic [15:0] d);
		case (op)
			fbc_pkg::OP_ENTER: begin
				step_data = (i == 3'd0) ? fbc_pkg::DAT_UNLOCK1 :
					(i == 3'd1) ? fbc_pkg::DAT_UNLOCK2 : fbc_pkg::DAT_BYP_ENTR;
			end
			fbc_pkg::OP_PROG: step_data = (i == 3'd0) ? fbc_pkg::DAT_BYP_PROG : d;
			fbc_pkg::OP_EXIT: begin
				step_data = (i == 3'd0) ? fbc_pkg::DAT_BYP_EXT1 : fbc_pkg::DAT_BYP_EXT2;
			end
			fbc_pkg::OP_EVAL:  step_data = fbc_pkg::DAT_EVAL;
			fbc_pkg::OP_BLANK: step_data = fbc_pkg::DAT_BLANK;
			fbc_pkg::OP_CHIP: begin
				case (i)
					3'd0, 3'd3: step_data = fbc_pkg::DAT_UNLOCK1;
					3'd1, 3'd4: step_data = fbc_pkg::DAT_UNLOCK2;
					3'd2:       step_data = CHIP_SETUP_DATA;
					default:    step_data = CHIP_ERASE_DATA;
				endcase
			end
			default: step_data = d;
		endcase
	endfunction

	function automatic logic needs_poll(input logic [2:0] op);
		needs_poll = (op == fbc_pkg::OP_PROG || op == fbc_pkg::OP_EVAL ||
			op == fbc_pkg::OP_BLANK || op == fbc_pkg::OP_CHIP);
	endfunction

	fbc_sync #(.W(16)) u_dq_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in (flash_dq_in),
		.sync_out (dq_sync)
	);

	fbc_sync #(.W(1)) u_rb_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in (ready_busy_n),
		.sync_out (rb_sync)
	);

	fbc_cycle #(.ADDR_W(ADDR_W)) u_cycle (
		.core_clk   (core_clk),
		.rst        (rst),
		.start      (s.cyc_start),
		.rd         (s.st == S_POLL_WAIT),
		.addr       (s.st == S_POLL_WAIT ? s.addr : step_addr(s.op, s.idx, s.addr)),
		.wdata      (step_data(s.op, s.idx, s.data)),
		.din_sync   (dq_sync),
		.pin_addr   (flash_addr),
		.pin_dq_out (flash_dq_out),
		.pin_dq_oe  (flash_dq_oe),
		.pin_ce_n   (flash_ce_n),
		.pin_we_n   (flash_we_n),
		.pin_oe_n   (flash_oe_n),
		.done       (cyc_done),
		.rdata      (cyc_rdata)
	);

	assign wr_cmd = sw_wr && sw_addr == fbc_pkg::REG_CMD;
	assign cmd    = sw_wdata[2:0];
	assign busy   = s.st != S_IDLE;
	// Bypass allows only its own program/exit; a hardware reset is always allowed
	assign legal  = s.in_bypass ?
		(cmd == fbc_pkg::OP_PROG || cmd == fbc_pkg::OP_EXIT) :
		(cmd != fbc_pkg::OP_PROG && cmd != fbc_pkg::OP_EXIT);
	// Toggle bit steady over two reads means the embedded operation ended
	assign poll_end = s.st == S_POLL_WAIT && cyc_done && s.op != fbc_pkg::OP_READ &&
		!s.first && cyc_rdata[fbc_pkg::TOGGLE_BIT] == s.prev;

	always_comb begin
		next_s           = s;
		next_s.cyc_start = 1'b0;
		next_s.sw_rdata  = 32'h0000_0000;
		if (sw_rd) begin
			case (sw_addr)
				fbc_pkg::REG_ADDR:   next_s.sw_rdata = 32'(s.addr);
				fbc_pkg::REG_DATA:   next_s.sw_rdata = {16'h0000, s.data};
				fbc_pkg::REG_RDATA:  next_s.sw_rdata = {16'h0000, s.rdata};
				fbc_pkg::REG_STATUS: begin
					next_s.sw_rdata[fbc_pkg::ST_BUSY]    = busy;
					next_s.sw_rdata[fbc_pkg::ST_DONE]    = s.done;
					next_s.sw_rdata[fbc_pkg::ST_FAIL]    = s.fail;
					next_s.sw_rdata[fbc_pkg::ST_TIMEOUT] = s.timeout;
					next_s.sw_rdata[fbc_pkg::ST_ABORT]   = s.aborted;
					next_s.sw_rdata[fbc_pkg::ST_REFUSED] = s.refused;
					next_s.sw_rdata[fbc_pkg::ST_BYPASS]  = s.in_bypass;
				end
				default: next_s.sw_rdata = 32'h0000_0000;
			endcase
		end
		if (sw_wr && !busy && sw_addr == fbc_pkg::REG_ADDR) begin
			next_s.addr = sw_wdata[ADDR_W-1:0];
		end
		if (sw_wr && !busy && sw_addr == fbc_pkg::REG_DATA) begin
			next_s.data = sw_wdata[15:0];
		end

		case (s.st)
			S_ISSUE: begin
				next_s.cyc_start = 1'b1;
				next_s.st        = S_WAIT_WR;
			end
			S_WAIT_WR: begin
				if (cyc_done) begin
					next_s.idx = s.idx + 3'd1;
					if (s.idx + 3'd1 == step_count(s.op)) begin
						if (needs_poll(s.op)) begin
							next_s.timer = 16'(fbc_pkg::BUSY_CYC);
							next_s.st    = S_SETTLE;
						end else begin
							next_s.in_bypass = (s.op == fbc_pkg::OP_ENTER);
							next_s.done      = 1'b1;
							next_s.st        = S_IDLE;
						end
					end else begin
						next_s.st = S_ISSUE;
					end
				end
			end
			S_SETTLE: begin
				if (s.timer == 16'h0000) begin
					next_s.first = 1'b1;
					next_s.polls = 32'h0000_0000;
					next_s.st    = S_POLL_RD;
				end else begin
					next_s.timer = s.timer - 16'h0001;
				end
			end
			S_POLL_RD: begin
				next_s.cyc_start = 1'b1;
				next_s.st        = S_POLL_WAIT;
			end
			S_POLL_WAIT: begin
				if (cyc_done) begin
					next_s.rdata = cyc_rdata;
					if (s.op == fbc_pkg::OP_READ) begin
						next_s.done = 1'b1;
						next_s.st   = S_IDLE;
					end else if (poll_end) begin
						// Ready/busy held low after the end marks a failed check
						next_s.fail = !rb_sync;
						next_s.done = 1'b1;
						next_s.st   = S_IDLE;
					end else if (s.polls == 32'(POLL_LIMIT - 1)) begin
						next_s.timeout = 1'b1;
						next_s.done    = 1'b1;
						next_s.st      = S_IDLE;
					end else begin
						next_s.prev  = cyc_rdata[fbc_pkg::TOGGLE_BIT];
						next_s.first = 1'b0;
						next_s.polls = s.polls + 32'h0000_0001;
						next_s.st    = S_POLL_RD;
					end
				end
			end
			default: next_s.st = s.st;
		endcase

		if (s.st == S_RST_LOW && s.timer == 16'h0000) begin
			next_s.timer = 16'(fbc_pkg::RPH_CYC - 1);
			next_s.st    = S_RST_REC;
		end else if (s.st == S_RST_LOW) begin
			next_s.timer = s.timer - 16'h0001;
		end
		if (s.st == S_RST_REC && s.timer == 16'h0000) begin
			next_s.done = 1'b1;
			next_s.st   = S_IDLE;
		end else if (s.st == S_RST_REC) begin
			next_s.timer = s.timer - 16'h0001;
		end

		if (wr_cmd && cmd == fbc_pkg::OP_HWRST) begin
			next_s.aborted   = busy && s.op == fbc_pkg::OP_CHIP;
			next_s.in_bypass = 1'b0;
			next_s.done      = 1'b0;
			next_s.op        = cmd;
			next_s.timer     = 16'(fbc_pkg::RST_CYC - 1);
			next_s.st        = S_RST_LOW;
		end else if (wr_cmd && (busy || !legal)) begin
			next_s.refused = 1'b1;
		end else if (wr_cmd) begin
			next_s.op      = cmd;
			next_s.idx     = 3'd0;
			next_s.done    = 1'b0;
			next_s.fail    = 1'b0;
			next_s.timeout = 1'b0;
			next_s.aborted = 1'b0;
			next_s.refused = 1'b0;
			next_s.st      = (cmd == fbc_pkg::OP_READ) ? S_POLL_RD : S_ISSUE;
		end
		// Registered so the reset pin never glitches on state decode
		next_s.rst_pin_n = next_s.st != S_RST_LOW;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s           <= '0;
			s.st        <= S_IDLE;
			s.rst_pin_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign sw_rdata      = s.sw_rdata;
	assign flash_reset_n = s.rst_pin_n;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence reset_ordered;
		wr_cmd && cmd == fbc_pkg::OP_HWRST;
	endsequence

	a_enter_sets: assert property (
		(s.st == S_WAIT_WR && cyc_done && s.op == fbc_pkg::OP_ENTER && s.idx == 3'd2 &&
			!wr_cmd) |=> s.in_bypass && s.done)
		else $error("bypass not entered after third write");
	a_prog_setup: assert property (
		($fell(flash_we_n) && s.op == fbc_pkg::OP_PROG && s.idx == 3'd0) |->
			flash_dq_out == fbc_pkg::DAT_BYP_PROG)
		else $error("bypass program setup data wrong");
	a_exit_clears: assert property (
		(s.st == S_WAIT_WR && cyc_done && s.op == fbc_pkg::OP_EXIT && s.idx == 3'd1)
			|=> !s.in_bypass)
		else $error("bypass not left after exit");
	a_bypass_guard: assert property (
		(s.in_bypass && busy) |-> (s.op == fbc_pkg::OP_PROG || s.op == fbc_pkg::OP_EXIT))
		else $error("foreign operation inside bypass");
	a_eval_word: assert property (
		($fell(flash_we_n) && s.op == fbc_pkg::OP_EVAL) |->
			flash_addr[15:0] == fbc_pkg::ADR_UNLOCK1 && flash_dq_out == fbc_pkg::DAT_EVAL)
		else $error("evaluation command word wrong");
	a_busy_refuse: assert property (
		(wr_cmd && busy && cmd != fbc_pkg::OP_HWRST) |=> $stable(s.op) && s.refused)
		else $error("command taken while busy");
	a_chip_six: assert property (
		(s.st == S_SETTLE && s.op == fbc_pkg::OP_CHIP) |-> s.idx == 3'd6)
		else $error("chip erase polled before sixth write");
	a_fail_latch: assert property (
		(poll_end && !rb_sync && !wr_cmd) |=> s.fail && s.done && !busy)
		else $error("failed check not reported");
	a_reset_hold: assert property (
		reset_ordered |=> (!flash_reset_n)[*8])
		else $error("hardware reset pulse too short");
endmodule

// ===== pkg/fbc_pkg.sv
package fbc_pkg;
	// Core clock rate and derived cycle counts (least times round up)
	localparam int CLK_MHZ     = 200;
	localparam int T_SETUP_NS  = 20;
	localparam int T_WE_NS     = 35;
	localparam int T_HOLD_NS   = 20;
	localparam int T_ACC_NS    = 100;
	localparam int T_RST_NS    = 500;
	localparam int T_RPH_NS    = 1000;
	localparam int T_BUSY_NS   = 500;
	localparam int SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int WE_CYC      = (T_WE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC    = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_CYC    = 2;
	localparam int RD_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
	localparam int RST_CYC     = (T_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int RPH_CYC     = (T_RPH_NS * CLK_MHZ + 999) / 1000;
	localparam int BUSY_CYC    = (T_BUSY_NS * CLK_MHZ + 999) / 1000;

	// Flash word addresses and command data
	localparam logic [15:0] ADR_UNLOCK1  = 16'h0555;
	localparam logic [15:0] ADR_UNLOCK2  = 16'h02AA;
	localparam logic [15:0] DAT_UNLOCK1  = 16'h00AA;
	localparam logic [15:0] DAT_UNLOCK2  = 16'h0055;
	localparam logic [15:0] DAT_BYP_ENTR = 16'h0020;
	localparam logic [15:0] DAT_BYP_PROG = 16'h00A0;
	localparam logic [15:0] DAT_BYP_EXT1 = 16'h0090;
	localparam logic [15:0] DAT_BYP_EXT2 = 16'h0000;
	localparam logic [15:0] DAT_EVAL     = 16'h0035;
	localparam logic [15:0] DAT_BLANK    = 16'h0033;
	localparam int          SECT_LSB     = 16;
	localparam int          TOGGLE_BIT   = 6;

	// Software register indices
	localparam logic [2:0] REG_CMD    = 3'h0;
	localparam logic [2:0] REG_ADDR   = 3'h1;
	localparam logic [2:0] REG_DATA   = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_RDATA  = 3'h4;

	// Operation codes written to the command register
	localparam logic [2:0] OP_READ  = 3'h0;
	localparam logic [2:0] OP_ENTER = 3'h1;
	localparam logic [2:0] OP_PROG  = 3'h2;
	localparam logic [2:0] OP_EXIT  = 3'h3;
	localparam logic [2:0] OP_EVAL  = 3'h4;
	localparam logic [2:0] OP_BLANK = 3'h5;
	localparam logic [2:0] OP_CHIP  = 3'h6;
	localparam logic [2:0] OP_HWRST = 3'h7;

	// Status register bit positions
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_FAIL    = 2;
	localparam int ST_TIMEOUT = 3;
	localparam int ST_ABORT   = 4;
	localparam int ST_REFUSED = 5;
	localparam int ST_BYPASS  = 6;
endpackage

// ===== verilog/fbc_sync.sv
`timescale 1ns/100ps
module fbc_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} fbc_sync_s;

	fbc_sync_s s;
	fbc_sync_s next_s;

	initial begin
		if (W < 1) $error("fbc_sync: W must be at least 1");
	end

	always_comb begin
		next_s        = s;
		next_s.meta   = async_in;
		next_s.stable = s.meta;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stable;
endmodule

// ===== verilog/fbc_cycle.sv
`timescale 1ns/100ps
module fbc_cycle #(
	parameter int ADDR_W = 26
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire logic              rd,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [15:0]       wdata,
	input  wire logic [15:0]       din_sync,
	output logic      [ADDR_W-1:0] pin_addr,
	output logic      [15:0]       pin_dq_out,
	output logic                   pin_dq_oe,
	output logic                   pin_ce_n,
	output logic                   pin_we_n,
	output logic                   pin_oe_n,
	output logic                   done,
	output logic      [15:0]       rdata
);
	typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fbc_cy_e;
	typedef struct packed {
		fbc_cy_e           ph;
		logic [7:0]        cnt;
		logic              is_rd;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       dq;
		logic              oe;
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic              done;
		logic [15:0]       rdata;
	} fbc_cycle_s;

	fbc_cycle_s s;
	fbc_cycle_s next_s;

	initial begin
		if (fbc_pkg::RD_CYC > 255 || fbc_pkg::SETUP_CYC < 1) $error("fbc_cycle: bad timing");
	end

	always_comb begin
		next_s      = s;
		next_s.done = 1'b0;
		case (s.ph)
			CY_IDLE: begin
				if (start) begin
					next_s.addr  = addr;
					next_s.dq    = wdata;
					next_s.oe    = !rd;
					next_s.ce_n  = 1'b0;
					next_s.is_rd = rd;
					next_s.cnt   = 8'(fbc_pkg::SETUP_CYC - 1);
					next_s.ph    = CY_SETUP;
				end
			end
			CY_SETUP: begin
				if (s.cnt == 8'h00) begin
					next_s.we_n = s.is_rd;
					next_s.oe_n = !s.is_rd;
					next_s.cnt  = s.is_rd ? 8'(fbc_pkg::RD_CYC - 1) : 8'(fbc_pkg::WE_CYC - 1);
					next_s.ph   = CY_STROBE;
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			CY_STROBE: begin
				if (s.cnt == 8'h00) begin
					if (s.is_rd) begin
						next_s.rdata = din_sync;
					end
					// Device latches data on this rising edge
					next_s.we_n = 1'b1;
					next_s.oe_n = 1'b1;
					next_s.cnt  = 8'(fbc_pkg::HOLD_CYC - 1);
					next_s.ph   = CY_HOLD;
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			CY_HOLD: begin
				if (s.cnt == 8'h00) begin
					next_s.ce_n = 1'b1;
					next_s.oe   = 1'b0;
					next_s.done = 1'b1;
					next_s.ph   = CY_IDLE;
				end else begin
					next_s.cnt = s.cnt - 8'h01;
				end
			end
			default: next_s.ph = CY_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s      <= '0;
			s.ph   <= CY_IDLE;
			s.ce_n <= 1'b1;
			s.we_n <= 1'b1;
			s.oe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign pin_addr   = s.addr;
	assign pin_dq_out = s.dq;
	assign pin_dq_oe  = s.oe;
	assign pin_ce_n   = s.ce_n;
	assign pin_we_n   = s.we_n;
	assign pin_oe_n   = s.oe_n;
	assign done       = s.done;
	assign rdata      = s.rdata;

	a_we_width: assert property (@(posedge core_clk) disable iff (rst)
		$fell(pin_we_n) |-> (!pin_we_n && pin_dq_oe && !pin_ce_n)[*7] ##1 pin_we_n)
		else $error("write strobe width wrong");
	a_bus_clash: assert property (@(posedge core_clk) disable iff (rst)
		!pin_oe_n |-> (!pin_dq_oe && pin_we_n && !pin_ce_n))
		else $error("host drives data during read");
endmodule

// ===== dv/fbc_flash_model.sv
`timescale 1ns/100ps
module fbc_flash_model #(
	parameter int          PROT_SECT = 1,
	parameter int          BAD_SECT  = 3,
	parameter logic [15:0] SETUP_D   = 16'h0080,
	parameter logic [15:0] ERASE_D   = 16'h0010
) (
	input  wire logic [25:0] addr,
	input  wire logic [15:0] dq_bus,
	output logic      [15:0] dq_out,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        reset_n,
	output logic             ready_busy_n
);
	logic [15:0] mem [int];
	logic [15:0] keep [int];
	logic [15:0] last = 16'h0000;
	int          st = 0;
	int          bst = 0;
	int          busy_t = 0;
	logic        byp = 0;
	logic        fail = 0;
	logic        tog = 0;
	logic        u1, u2, c5;

	function automatic logic [15:0] rd(input logic [25:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction

	// Early return: the scan stops at the first programmed word
	function automatic logic blank(input int s);
		foreach (mem[k]) if ((k >> 16) == s && mem[k] != 16'hFFFF) return 1'b0;
		return 1'b1;
	endfunction

	task automatic chip();
		keep.delete();
		foreach (mem[k]) if ((k >> 16) == PROT_SECT) keep[k] = mem[k];
		mem = keep;
		busy_t = 300;
	endtask

	assign ready_busy_n = !(busy_t > 0 || fail);
	// Released bus shows the inverse so a stale value never passes
	assign dq_out = (!ce_n && !oe_n) ? (busy_t > 0 ? {9'h000, tog, 6'h00} : rd(addr)) : ~last;
	always @(dq_out) if (!ce_n && !oe_n) last = dq_out;
	always @(negedge oe_n) if (!ce_n && busy_t > 0) tog = !tog;

	always @(posedge we_n) if (!ce_n && reset_n && busy_t == 0 && !fail) begin
		u1 = dq_bus == 16'h00AA && addr[15:0] == 16'h0555;
		u2 = dq_bus == 16'h0055 && addr[15:0] == 16'h02AA;
		c5 = addr[15:0] == 16'h0555;
		if (byp) begin
			if (bst == 1) begin
				mem[addr] = rd(addr) & dq_bus;
				busy_t = 5;
				bst = 0;
			end else if (bst == 2) begin
				byp = dq_bus != 16'h0000;
				bst = 0;
			end else bst = (dq_bus == 16'h00A0) ? 1 : (dq_bus == 16'h0090) ? 2 : 0;
		end else case (st)
			0: begin
				st = u1 ? 1 : 0;
				if (c5 && dq_bus == 16'h0035) begin
					fail = addr[25:16] == BAD_SECT;
					busy_t = 100;
				end
				if (c5 && dq_bus == 16'h0033) begin
					fail = !blank(addr[25:16]);
					busy_t = 100;
				end
			end
			1, 4: st = u2 ? st + 1 : 0;
			2: begin
				byp = c5 && dq_bus == 16'h0020;
				st = (c5 && dq_bus == SETUP_D) ? 3 : 0;
			end
			3: st = u1 ? 4 : 0;
			5: begin
				st = 0;
				if (c5 && dq_bus == ERASE_D) chip();
			end
			default: st = 0;
		endcase
	end

	initial forever begin
		#10;
		if (busy_t > 0) busy_t--;
	end
	always @(negedge reset_n) begin
		st = 0;
		bst = 0;
		byp = 0;
		fail = 0;
		busy_t = 0;
	end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic        core_clk = 0;
	logic        rst = 1;
	logic [2:0]  sw_addr = 3'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic        sw_wr = 0;
	logic        sw_rd = 0;
	logic [31:0] sw_rdata, s, v;
	logic [25:0] flash_addr;
	logic [15:0] flash_dq_out, mdl_dq, dq_bus;
	logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, ready_busy_n;
	int          err_count = 0;
	int          comparisons = 0;
	localparam logic [31:0] DN = 32'h1 << fbc_pkg::ST_DONE;
	localparam logic [31:0] FL = 32'h1 << fbc_pkg::ST_FAIL;
	localparam logic [31:0] RF = 32'h1 << fbc_pkg::ST_REFUSED;
	localparam logic [31:0] BY = 32'h1 << fbc_pkg::ST_BYPASS;
	localparam logic [31:0] BS = 32'h1 << fbc_pkg::ST_BUSY;
	localparam logic [31:0] AB = 32'h1 << fbc_pkg::ST_ABORT;

	assign dq_bus = flash_dq_oe ? flash_dq_out : mdl_dq;
	always #2.5 core_clk = !core_clk;

	fbc_ctrl u_fbc_ctrl (.core_clk(core_clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(dq_bus),
		.flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
		.flash_reset_n(flash_reset_n), .ready_busy_n(ready_busy_n));
	fbc_flash_model u_fbc_flash_model (.addr(flash_addr), .dq_bus(dq_bus), .dq_out(mdl_dq),
		.ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .reset_n(flash_reset_n),
		.ready_busy_n(ready_busy_n));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic sw_w(input logic [2:0] a, input logic [31:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_r(input logic [2:0] a, output logic [31:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		@(negedge core_clk);
		d = sw_rdata;
	endtask
	task automatic wait_idle();
		int i;
		repeat (2) @(posedge core_clk);
		for (i = 0; i < 4000; i++) begin
			sw_r(fbc_pkg::REG_STATUS, s);
			if (s[fbc_pkg::ST_BUSY] === 1'b0) break;
		end
		if (i == 4000) begin
			$display("[FAIL] %0t operation never finished", $time);
			err_count++;
			report_and_stop();
		end
	endtask
	task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [2:0] c);
		sw_w(fbc_pkg::REG_ADDR, a);
		sw_w(fbc_pkg::REG_DATA, d);
		sw_w(fbc_pkg::REG_CMD, {29'h0, c});
		wait_idle();
	endtask
	task automatic rdw(input logic [31:0] a, input logic [31:0] e);
		op(a, 32'h0, fbc_pkg::OP_READ);
		sw_r(fbc_pkg::REG_RDATA, v);
		chk(v, e);
	endtask

	task automatic t_regs();
		sw_r(fbc_pkg::REG_STATUS, v);
		chk(v, 32'h0);
		sw_r(3'h7, v);
		chk(v, 32'h0);
		op(32'h0123_4567, 32'h1234, fbc_pkg::OP_PROG);
		chk(s & (RF | BS), RF);
		sw_r(fbc_pkg::REG_ADDR, v);
		chk(v, 32'h0123_4567);
		sw_r(fbc_pkg::REG_DATA, v);
		chk(v, 32'h0000_1234);
		op(32'h0, 32'h0, fbc_pkg::OP_EXIT);
		chk(s & (RF | BS), RF);
	endtask
	task automatic t_bypass();
		op(32'h0, 32'h0, fbc_pkg::OP_ENTER);
		chk(s, DN | BY);
		chk({31'h0, u_fbc_flash_model.byp}, 32'h1);
		op(32'h0000_0010, 32'h5A5A, fbc_pkg::OP_PROG);
		chk(s, DN | BY);
		op(32'h0001_0011, 32'hA5A5, fbc_pkg::OP_PROG);
		chk(s, DN | BY);
		op(32'h0, 32'h0, fbc_pkg::OP_BLANK);
		chk(s & (RF | BS | BY), RF | BY);
		op(32'h0, 32'h0, fbc_pkg::OP_EXIT);
		chk(s, DN);
		chk({31'h0, u_fbc_flash_model.byp}, 32'h0);
		rdw(32'h0000_0010, 32'h5A5A);
	endtask
	task automatic t_eval();
		op(32'h0002_0000, 32'h0, fbc_pkg::OP_EVAL);
		chk(s, DN);
		op(32'h0003_0000, 32'h0, fbc_pkg::OP_EVAL);
		chk(s & ~DN, FL);
		chk({31'h0, ready_busy_n}, 32'h0);
		op(32'h0, 32'h0, fbc_pkg::OP_HWRST);
		chk({31'h0, ready_busy_n}, 32'h1);
	endtask
	task automatic t_blank();
		op(32'h0, 32'h0, fbc_pkg::OP_BLANK);
		chk(s & ~DN, FL);
		op(32'h0, 32'h0, fbc_pkg::OP_HWRST);
		op(32'h0002_0000, 32'h0, fbc_pkg::OP_BLANK);
		chk(s, DN);
	endtask
	task automatic t_chip();
		sw_w(fbc_pkg::REG_CMD, {29'h0, fbc_pkg::OP_CHIP});
		repeat (300) @(posedge core_clk);
		chk({31'h0, ready_busy_n}, 32'h0);
		sw_w(fbc_pkg::REG_CMD, {29'h0, fbc_pkg::OP_EVAL});
		sw_r(fbc_pkg::REG_STATUS, s);
		chk(s & (RF | BS), RF | BS);
		sw_w(fbc_pkg::REG_ADDR, 32'h0000_0001);
		wait_idle();
		chk(s & (FL | AB | BS), 32'h0);
		sw_r(fbc_pkg::REG_ADDR, v);
		chk(v, 32'h0002_0000);
		rdw(32'h0000_0010, 32'hFFFF);
		rdw(32'h0001_0011, 32'hA5A5);
		sw_w(fbc_pkg::REG_CMD, {29'h0, fbc_pkg::OP_CHIP});
		repeat (200) @(posedge core_clk);
		sw_w(fbc_pkg::REG_CMD, {29'h0, fbc_pkg::OP_HWRST});
		wait_idle();
		chk(s & (AB | BS), AB);
		chk({31'h0, ready_busy_n}, 32'h1);
		op(32'h0, 32'h0, fbc_pkg::OP_CHIP);
		chk(s, DN);
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_bypass();
		t_eval();
		t_blank();
		t_chip();
		report_and_stop();
	end
endmodule
